// >>> bench/test_watchdog_with_aux_control.sv
// self-checking bench for the watchdog with auxiliary control
// assumes wdaux_top on a 10 MHz clock with synchronous active-low reset
`timescale 1ns/1ns
module test_watchdog_with_aux_control;
    import wdaux_pkg::*;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic          clock         = 1'b0;
    logic          reset_n       = 1'b0;
    wdaux_sfr_type sfr           = '0;
    logic          idle_mode     = 1'b0;
    logic          external_move = 1'b0;
    logic          wake_int_n    = 1'b1;
    logic          pd_int_exit   = 1'b0;
    logic [7:0]    sfr_rdata;
    logic          reset_pin_out;
    logic          reset_pin_oe;
    logic          device_reset;
    logic          address_strobe;
    logic [7:0]    rd;
    logic [7:0]    wv;
    int            miscompares   = 0;
    int            num_checks    = 0;
    int            seed          = 76919;
    int            cyc           = 0;
    int            resets        = 0;
    int            aux_m         = 0;
    int            t0;
    int            n;
    // narrow counter keeps each overflow near 12k cycles
    localparam int WB            = 10;

    always #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    always @(negedge clock) if (device_reset === 1'b1) resets++;

    wdaux_top #(.WATCH_BITS(WB)) i_wdaux_top (
        .clock(clock), .reset_n(reset_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .idle_mode(idle_mode), .external_move(external_move),
        .wake_int_n(wake_int_n), .pd_int_exit(pd_int_exit),
        .reset_pin_in(1'b1), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .device_reset(device_reset),
        .address_strobe(address_strobe));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one access per call; the idle cycle after keeps strobes single
    task automatic sfr_access(input logic wr, input logic [7:0] a,
                              input logic [7:0] d);
        @(posedge clock);
        sfr <= '{write: wr, read: !wr, addr: a, wdata: d};
        @(posedge clock);
        sfr <= '0;
        #1 rd = sfr_rdata;
    endtask : sfr_access

    task automatic count_strobe(input int exp);
        n = 0;
        // the first edge after a change still strobes on the old setting
        @(posedge clock);
        repeat (60) @(negedge clock) if (address_strobe === 1'b1) n++;
        check(8'(n), 8'(exp));
    endtask : count_strobe

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // ----------------------------------------
    // watchdog: the whole run needs about 41k cycles
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        $display("mismatch at %0t: run timed out", $time);
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        sfr_access(1'b0, AUX_CONTROL_ADDR, 8'h00);
        check(rd, 8'h00);
        sfr_access(1'b0, SERVICE_PORT_ADDR, 8'h00);
        check(rd, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wv = 8'($random(seed)) & 8'h19;
            sfr_access(1'b1, AUX_CONTROL_ADDR, wv);
            aux_m = wv;
            sfr_access(1'b0, AUX_CONTROL_ADDR, 8'h00);
            check(rd, 8'(aux_m));
        end
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h00);
        count_strobe(10);
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h01);
        count_strobe(0);
        @(posedge clock) external_move <= 1'b1;
        count_strobe(10);
        @(posedge clock) external_move <= 1'b0;
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h00);
        $display("test registers and strobe done");
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_FIRST);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_SECOND);
        repeat (1200) @(posedge clock);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_FIRST);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_SECOND);
        t0 = cyc;
        // a broken pair and a stray byte must neither clear nor stop it
        repeat (1200) @(posedge clock);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_FIRST);
        sfr_access(1'b1, SERVICE_PORT_ADDR, 8'h00);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_SECOND);
        sfr_access(1'b1, SERVICE_PORT_ADDR, 8'h00);
        @(posedge clock) idle_mode <= 1'b1;
        repeat (1200) @(posedge clock);
        idle_mode <= 1'b0;
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h10);
        @(posedge clock) idle_mode <= 1'b1;
        repeat (1200) @(posedge clock);
        idle_mode <= 1'b0;
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h00);
        @(posedge clock) begin
            wake_int_n  <= 1'b0;
            pd_int_exit <= 1'b1;
        end
        @(posedge clock) pd_int_exit <= 1'b0;
        repeat (1200) @(posedge clock);
        wake_int_n <= 1'b1;
        $display("test service and hold done");
        // all ticks of 12 clocks plus 1200 halted idle edges and the
        // 1204 edges from wake to the filtered release of the hold
        n = 0;
        while (device_reset !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        n = cyc - t0 - (1 << WB) * MACHINE_PERIODS - 2404;
        check(8'((n > -17) && (n < 13)), 8'h01);
        check(reset_pin_out, 1'b1);
        n = 0;
        while (reset_pin_oe === 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check(8'(n), 8'd98);
        sfr_access(1'b0, AUX_CONTROL_ADDR, 8'h00);
        check(rd, 8'h00);
        // off after its own overflow: no second one may follow
        repeat ((1 << WB) * MACHINE_PERIODS + 200) @(posedge clock);
        check(8'(resets), 8'h01);
        $display("test overflow done");
        // inhibited: the device still resets, the pin stays an input
        sfr_access(1'b1, AUX_CONTROL_ADDR, 8'h08);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_FIRST);
        sfr_access(1'b1, SERVICE_PORT_ADDR, SERVICE_SECOND);
        wv = 8'h00;
        repeat ((1 << WB) * MACHINE_PERIODS + 150) begin
            @(negedge clock);
            if (reset_pin_oe !== 1'b0) wv = 8'h01;
        end
        check(8'(resets), 8'h02);
        check(wv, 8'h00);
        $display("test inhibited overflow done");
        summarize();
    end
endmodule : test_watchdog_with_aux_control

// >>> hdl/wdaux_pkg.sv
// package for the watchdog with auxiliary control
// assumes an 8-bit special-function-register write/read port on one clock
package wdaux_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] AUX_CONTROL_ADDR   = 8'h8e;
    localparam logic [7:0] SERVICE_PORT_ADDR  = 8'ha6;
    localparam logic [7:0] SERVICE_FIRST      = 8'h1e;
    localparam logic [7:0] SERVICE_SECOND     = 8'he1;

    // ----------------------------------------
    // aux_control fields
    // ----------------------------------------
    localparam int         STROBE_GATE_POS    = 0;
    localparam int         RESET_INHIBIT_POS  = 3;
    localparam int         IDLE_HALT_POS      = 4;
    localparam logic [2:0] AUX_RESET          = 3'h0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int         WATCH_WIDTH        = 14;
    localparam logic [13:0] WATCH_LIMIT       = 14'h3fff;
    localparam int         MACHINE_PERIODS    = 12;
    localparam int         STROBE_PERIODS     = 6;
    localparam int         RESET_OUT_PERIODS  = 98;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdaux_sfr_type;

    typedef struct packed {
        logic idle_halt;
        logic reset_inhibit;
        logic strobe_gate;
    } wdaux_aux_type;

endpackage : wdaux_pkg

// >>> hdl/wdaux_top.sv
// watchdog counter, service port and auxiliary control register
// assumes clock is the oscillator; sfr port comes from cpu logic on same clock
//
// What this block does
// - after any reset the watchdog is off until the enabling byte pair.
// - writing 1e then e1 to the service port at a6 enables the watchdog.
// - while on, the counter adds one per machine cycle with clock running.
// - the 14-bit counter overflows at 3fff and resets the whole device.
// - once on, software cannot turn it off; only a reset does.
// - the byte pair written while on clears the counter to zero.
// - the service port is write only and the counter is never visible.
// - on overflow the reset pin is driven high for 98 oscillator periods.
// - inhibit bit 0 lets the pin be driven; 1 leaves it input only.
// - idle-halt bit 0 keeps counting in idle; 1 pauses while idle.
// - strobe-gate 0 strobes at osc/6; 1 strobes only during moves.
// - one machine cycle is twelve oscillator periods.
// - after a power-down exit by interrupt, hold until the line is high.
// - a count halted by idle resumes from its held value when idle ends.
`timescale 1ns/1ns
module wdaux_top
    import wdaux_pkg::*;
#(
    // counter width; narrower only to shorten simulation
    parameter int WATCH_BITS = WATCH_WIDTH
)
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          reset_n,
    // special-function-register port
    input  wire wdaux_sfr_type sfr,
    output logic [7:0]         sfr_rdata,
    // cpu state
    input  wire logic          idle_mode,
    input  wire logic          external_move,
    input  wire logic          wake_int_n,
    input  wire logic          pd_int_exit,
    // reset pin, open drain style
    input  wire logic          reset_pin_in,
    output logic               reset_pin_out,
    output logic               reset_pin_oe,
    // device reset and strobe
    output logic               device_reset,
    output logic               address_strobe
);

    // overflow point is all ones, 3fff at the default width
    localparam logic [WATCH_BITS-1:0] COUNT_LIMIT = WATCH_LIMIT[WATCH_BITS-1:0];
    localparam logic [WATCH_BITS-1:0] COUNT_ONE   = WATCH_BITS'(1);

    if (WATCH_BITS < 2 || WATCH_BITS > WATCH_WIDTH) begin : g_width_check
        $error("watch counter width out of range");
    end

    // ----------------------------------------
    // pin synchroniser for the wake interrupt
    // ----------------------------------------
    logic [2:0] wake_sync_q, wake_sync_d;
    logic       wake_level_q, wake_level_d;

    always_comb begin
        wake_sync_d  = {wake_sync_q[1:0], wake_int_n};
        wake_level_d = wake_level_q;
        if (wake_sync_q[1] == wake_sync_q[2]) begin
            wake_level_d = wake_sync_q[2];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wake_sync_q  <= 3'h7;
            wake_level_q <= 1'h1;
        end else begin
            wake_sync_q  <= wake_sync_d;
            wake_level_q <= wake_level_d;
        end
    end

    // ----------------------------------------
    // aux control and service sequence
    // ----------------------------------------
    wdaux_aux_type aux_q, aux_d;
    logic          armed_q, armed_d;
    logic          enabled_q, enabled_d;
    logic          service;
    logic          overflow;

    always_comb begin
        aux_d     = aux_q;
        armed_d   = armed_q;
        enabled_d = enabled_q;
        service   = 1'h0;
        if (sfr.write && sfr.addr == AUX_CONTROL_ADDR) begin
            aux_d.idle_halt     = sfr.wdata[IDLE_HALT_POS];
            aux_d.reset_inhibit = sfr.wdata[RESET_INHIBIT_POS];
            aux_d.strobe_gate   = sfr.wdata[STROBE_GATE_POS];
        end
        if (sfr.write && sfr.addr == SERVICE_PORT_ADDR) begin
            armed_d = (sfr.wdata == SERVICE_FIRST);
            if (armed_q && sfr.wdata == SERVICE_SECOND) begin
                service   = 1'h1;
                enabled_d = 1'h1;
            end
        end
        if (overflow) begin
            enabled_d = 1'h0;
            armed_d   = 1'h0;
            aux_d     = AUX_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aux_q     <= AUX_RESET;
            armed_q   <= 1'h0;
            enabled_q <= 1'h0;
        end else begin
            aux_q     <= aux_d;
            armed_q   <= armed_d;
            enabled_q <= enabled_d;
        end
    end

    // reads: aux only; service port and counter read as zero
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (sfr.read && sfr.addr == AUX_CONTROL_ADDR) begin
            rdata_d[IDLE_HALT_POS]     = aux_q.idle_halt;
            rdata_d[RESET_INHIBIT_POS] = aux_q.reset_inhibit;
            rdata_d[STROBE_GATE_POS]   = aux_q.strobe_gate;
        end
    end

    // ----------------------------------------
    // machine cycle prescaler and watch counter
    // ----------------------------------------
    logic [3:0]             pre_q, pre_d;
    logic                   tick;
    logic [WATCH_BITS-1:0]  count_q, count_d;
    logic                   pd_hold_q, pd_hold_d;
    logic                   run;

    always_comb begin
        tick  = (pre_q == 4'(MACHINE_PERIODS - 1));
        pre_d = tick ? 4'h0 : pre_q + 4'h1;
        // held after an interrupt wake until the line goes high
        pd_hold_d = pd_hold_q;
        if (pd_int_exit) begin
            pd_hold_d = 1'h1;
        end else if (wake_level_d && !wake_level_q) begin
            // only a rising filtered level ends it; just after the wake
            // the synchroniser still shows the old high level
            pd_hold_d = 1'h0;
        end
        run = enabled_q && tick && !pd_hold_q
              && !(idle_mode && aux_q.idle_halt);
        count_d  = count_q;
        overflow = 1'h0;
        if (run) begin
            if (count_q == COUNT_LIMIT) begin
                overflow = 1'h1;
            end else begin
                count_d = count_q + COUNT_ONE;
            end
        end
        if (service || overflow || !enabled_q) begin
            count_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pre_q     <= 4'h0;
            count_q   <= '0;
            pd_hold_q <= 1'h0;
        end else begin
            pre_q     <= pre_d;
            count_q   <= count_d;
            pd_hold_q <= pd_hold_d;
        end
    end

    // ----------------------------------------
    // reset pulse out and strobe
    // ----------------------------------------
    logic [6:0] rst_cnt_q, rst_cnt_d;
    logic       pin_oe_d, dev_rst_d;
    logic       pulse_inh_q, pulse_inh_d;
    logic [2:0] stb_q, stb_d;
    logic       strobe_d;

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (overflow) begin
            rst_cnt_d = 7'(RESET_OUT_PERIODS);
        end else if (rst_cnt_q != 7'h0) begin
            rst_cnt_d = rst_cnt_q - 7'h1;
        end
        // overflow clears aux, so the inhibit is kept for the whole pulse
        pulse_inh_d = overflow ? aux_q.reset_inhibit : pulse_inh_q;
        pin_oe_d  = (rst_cnt_d != 7'h0) && !pulse_inh_d;
        dev_rst_d = overflow;
        stb_d     = (stb_q == 3'(STROBE_PERIODS - 1)) ? 3'h0 : stb_q + 3'h1;
        strobe_d  = (stb_q == 3'h0)
                    && (!aux_q.strobe_gate || external_move);
    end

    logic pin_oe_q, dev_rst_q, strobe_q, pin_out_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rst_cnt_q   <= 7'h0;
            pulse_inh_q <= 1'h0;
            pin_out_q   <= 1'h0;
            pin_oe_q  <= 1'h0;
            dev_rst_q <= 1'h0;
            stb_q     <= 3'h0;
            strobe_q  <= 1'h0;
            sfr_rdata <= 8'h00;
        end else begin
            rst_cnt_q   <= rst_cnt_d;
            pulse_inh_q <= pulse_inh_d;
            pin_out_q   <= pin_oe_d;
            pin_oe_q  <= pin_oe_d;
            dev_rst_q <= dev_rst_d;
            stb_q     <= stb_d;
            strobe_q  <= strobe_d;
            sfr_rdata <= rdata_d;
        end
    end

    assign reset_pin_oe   = pin_oe_q;
    assign reset_pin_out  = pin_out_q;
    assign device_reset   = dev_rst_q;
    assign address_strobe = strobe_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_off_after_reset;
        @(posedge clock) $rose(reset_n) |-> !enabled_q;
    endproperty
    a_off_after_reset: assert property (p_off_after_reset)
        else $error("watchdog on after reset");

    property p_enable_seq;
        @(posedge clock) disable iff (!reset_n)
        (sfr.write && sfr.addr == SERVICE_PORT_ADDR
         && sfr.wdata == SERVICE_SECOND && armed_q && !overflow)
        |=> enabled_q && count_q == '0;
    endproperty
    a_enable_seq: assert property (p_enable_seq)
        else $error("pair did not enable and clear");

    property p_stays_on;
        @(posedge clock) disable iff (!reset_n)
        enabled_q && !overflow |=> enabled_q;
    endproperty
    a_stays_on: assert property (p_stays_on)
        else $error("watchdog turned off");

    property p_count_step;
        @(posedge clock) disable iff (!reset_n)
        run && !service && count_q != COUNT_LIMIT
        |=> count_q == $past(count_q) + COUNT_ONE;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count did not step");

    property p_idle_hold;
        @(posedge clock) disable iff (!reset_n)
        idle_mode && aux_q.idle_halt && !service && enabled_q
        |=> count_q == $past(count_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("count moved in halted idle");

    property p_overflow_reset;
        @(posedge clock) disable iff (!reset_n)
        overflow |=> device_reset && count_q == '0;
    endproperty
    a_overflow_reset: assert property (p_overflow_reset)
        else $error("overflow did not reset");

    property p_pulse_len;
        @(posedge clock) disable iff (!reset_n)
        overflow && !aux_q.reset_inhibit
        |=> reset_pin_oe [*8] ##90 reset_pin_oe ##1 !reset_pin_oe;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse not 98 periods");

    property p_inhibit;
        @(posedge clock) disable iff (!reset_n)
        aux_q.reset_inhibit |=> !reset_pin_oe;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("pin driven while inhibited");

    property p_pulse_inhibit;
        @(posedge clock) disable iff (!reset_n)
        overflow && aux_q.reset_inhibit |=> !reset_pin_oe [*8];
    endproperty
    a_pulse_inhibit: assert property (p_pulse_inhibit)
        else $error("pin driven after inhibited overflow");

    property p_strobe_gate;
        @(posedge clock) disable iff (!reset_n)
        aux_q.strobe_gate && !external_move |=> !address_strobe;
    endproperty
    a_strobe_gate: assert property (p_strobe_gate)
        else $error("strobe outside move");

    property p_service_read;
        @(posedge clock) disable iff (!reset_n)
        sfr.read && sfr.addr == SERVICE_PORT_ADDR |=> sfr_rdata == 8'h00;
    endproperty
    a_service_read: assert property (p_service_read)
        else $error("service port readable");

endmodule : wdaux_top
